// ---- rtl/supervisor_timer_defines.vh ----
// Constants for the supervisor timer: register map, fields, timing.
// Assumes inclusion by bare name from the rtl files.
`ifndef SUPERVISOR_TIMER_DEFINES_VH
`define SUPERVISOR_TIMER_DEFINES_VH
`define WDT_CTRL_ADDR 4'h0
`define WDT_STATUS_ADDR 4'h4
`define WDT_CTRL_RESET 8'h7f
`define WDT_ACT_BIT 7
`define WDT_TOP_BIT 6
`define WDT_PRESCALE 16384
`define WDT_TB_PERIOD 16'd64
`define WDT_TB_LSB0 8'd59
`define WDT_TB_LSB1 8'd53
`define WDT_TB_LSB2 8'd35
`define WDT_TB_LSB3 8'd54
`define WDT_WAKE_SHORT 256
`define WDT_WAKE_LONG 4096
`define WDT_RST_PULSE_NS 500
`define WDT_CLK_NS 5
`define WDT_RST_CYCLES ((`WDT_RST_PULSE_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS)
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// ---- rtl/tick_prescaler.v ----
// Run-gated prescaler giving one-cycle decrement enables.
// Assumes osc_clock enable pulses from the clock controller divider.
`timescale 1ns/1ps
`include "supervisor_timer_defines.vh"
module tick_prescaler #(
	parameter integer DIV = `WDT_PRESCALE
) (
	input wire aclk,
	input wire aresetn,
	input wire osc_clock,
	input wire [1:0] timebase_select,
	input wire run,
	output reg tick
);
	localparam integer LAST_I = DIV - 1;
	localparam [13:0] LAST = LAST_I[13:0];
	reg [13:0] phase;
	// Reload phase after each tick follows the timebase divider offset; reset loads 0
	function [13:0] start_phase;
		input [1:0] sel;
		reg [7:0] lsb;
		begin
			case (sel)
			2'd0: lsb = `WDT_TB_LSB0;
			2'd1: lsb = `WDT_TB_LSB1;
			2'd2: lsb = `WDT_TB_LSB2;
			default: lsb = `WDT_TB_LSB3;
			endcase
			// Times 64 is a shift; no multiplier needed
			start_phase = {lsb, 6'b000000};
		end
	endfunction
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 14'h0000;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (osc_clock && run) begin
				// Writes never touch the phase
				if (phase == LAST) begin
					phase <= start_phase(timebase_select);
					tick <= 1'b1;
				end else begin
					phase <= phase + 14'h0001;
				end
			end
		end
	end
endmodule

// ---- rtl/supervisor_timer.v ----
// Summary of operation
// - First decrement after 16384 oscillator clocks, then every 16384 minus 64x timebase offset
// - Active watchdog resets when top bit clears, except on the plain-halt decrement
// - Activation bit set by software only
// - Inactive watchdog counts but never times out
// - Control register reads 0x7f after reset
// - Hardware option forces watchdog always active
// - Slow and wait modes change nothing
// - Plain halt: one decrement, then freeze
// - External wake from plain halt resumes after 256/4096 clocks
// - Reset from halt restores reset state
// - Plain halt with halt-reset option causes reset
// - Active-halt freezes, wake resumes at once
// - Reset from active-halt delays count restart
// - Low six bits set delay in prescaler periods
// - Prescaler phase tied to timebase divider
// - Counter runs even while inactive
// - Write clearing top bit resets immediately when active or setting the activation bit
// - Timeout drives reset line about 500 ns
//
// Supervisor timer with AXI4-Lite register access.
// Assumes halt/wake strobes from the core, one clock domain.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "supervisor_timer_defines.vh"
module supervisor_timer #(
	parameter integer WAKE_SHORT = `WDT_WAKE_SHORT,
	parameter integer WAKE_LONG = `WDT_WAKE_LONG,
	parameter integer RST_CYCLES = `WDT_RST_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire osc_clock,
	input wire [1:0] timebase_select,
	input wire timebase_irq_enable,
	input wire halt_reset_option,
	input wire hw_watchdog_option,
	input wire long_wake_delay,
	input wire halt_strobe,
	input wire ext_wake,
	input wire osc_wake,
	input wire cold_from_halt,
	output reg reset_request,
	output reg reset_line_n,
	output reg halted
);
	localparam [7:0] CTRL_RESET = `WDT_CTRL_RESET;
	localparam integer RST_LAST = RST_CYCLES - 1;
	localparam [6:0] RST_LOAD = RST_LAST[6:0];
	localparam [12:0] WAKE_L = WAKE_LONG[12:0];
	localparam [12:0] WAKE_S = WAKE_SHORT[12:0];
	localparam [3:0] ST_RUN = 4'b0001;
	localparam [3:0] ST_HALT_ONE = 4'b0010;
	localparam [3:0] ST_FROZEN = 4'b0100;
	localparam [3:0] ST_DELAY = 4'b1000;

	reg [3:0] state;
	reg activation_bit;
	reg [6:0] count;
	reg [12:0] delay_cnt;
	reg [6:0] pulse_cnt;
	reg [3:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	reg restart_pending;
	wire tick;
	wire active;
	wire run;
	wire do_write;
	wire hit_ctrl;
	wire [6:0] next_count;
	wire timeout;
	wire soft_reset;
	wire halt_reset;

	// Slow and wait are not inputs at all: they cannot matter
	assign run = (state == ST_RUN) || (state == ST_HALT_ONE);
	assign active = activation_bit | hw_watchdog_option;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign hit_ctrl = (aw_addr == `WDT_CTRL_ADDR) && w_strb[0];
	assign next_count = count - 7'h01;
	// Decrement from 0x40 is the only tick that drops the top bit
	assign timeout = tick && (count == 7'h40) && active;
	assign soft_reset = do_write && hit_ctrl && !w_data[`WDT_TOP_BIT] &&
		(w_data[`WDT_ACT_BIT] | active);
	assign halt_reset = halt_strobe && state == ST_RUN &&
		!timebase_irq_enable && halt_reset_option;

	tick_prescaler #(
		.DIV(`WDT_PRESCALE)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.osc_clock(osc_clock),
		.timebase_select(timebase_select),
		.run(run),
		.tick(tick)
	);

	// Counter and activation bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			activation_bit <= 1'b0;
			count <= CTRL_RESET[6:0];
		end else begin
			if (do_write && hit_ctrl) begin
				count <= w_data[6:0];
				if (w_data[`WDT_ACT_BIT])
					activation_bit <= 1'b1;
			end else if (tick) begin
				count <= next_count;
			end
		end
	end

	// Low-power sequencing
	always @(posedge aclk) begin
		if (!aresetn) begin
			// A reset out of a halt delays the restart
			state <= ST_RUN;
			restart_pending <= 1'b1;
			delay_cnt <= 13'h0000;
			halted <= 1'b0;
		end else begin
			if (restart_pending) begin
				restart_pending <= 1'b0;
				if (cold_from_halt) begin
					state <= ST_DELAY;
					delay_cnt <= long_wake_delay ? WAKE_L : WAKE_S;
					halted <= 1'b0;
				end
			end else begin
				case (state)
				ST_RUN: begin
					if (halt_strobe && !halt_reset) begin
						halted <= 1'b1;
						state <= timebase_irq_enable ? ST_FROZEN :
							ST_HALT_ONE;
					end
				end
				ST_HALT_ONE: begin
					if (tick)
						state <= ST_FROZEN;
				end
				ST_FROZEN: begin
					if (osc_wake && timebase_irq_enable) begin
						state <= ST_RUN;
						halted <= 1'b0;
					end else if (ext_wake) begin
						halted <= 1'b0;
						if (timebase_irq_enable) begin
							state <= ST_RUN;
						end else begin
							state <= ST_DELAY;
							delay_cnt <= long_wake_delay ? WAKE_L : WAKE_S;
						end
					end
				end
				ST_DELAY: begin
					if (delay_cnt <= 13'h0001)
						state <= ST_RUN;
					else
						delay_cnt <= delay_cnt - 13'h0001;
				end
				default: state <= ST_RUN;
				endcase
			end
		end
	end

	// Reset request and reset line
	always @(posedge aclk) begin
		if (!aresetn) begin
			reset_request <= 1'b0;
			reset_line_n <= 1'b1;
			pulse_cnt <= 7'h00;
		end else begin
			// Frozen states give no ticks, so no timeout there
			reset_request <= (timeout && state != ST_HALT_ONE) ||
				soft_reset || halt_reset;
			if (reset_request) begin
				reset_line_n <= 1'b0;
				pulse_cnt <= RST_LOAD;
			end else if (pulse_cnt != 7'h00) begin
				pulse_cnt <= pulse_cnt - 7'h01;
			end else begin
				reset_line_n <= 1'b1;
			end
		end
	end

	// AXI4-Lite write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `WDT_CTRL_ADDR) ? `AXI_OKAY :
					`AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `AXI_OKAY;
				case (s_axi_araddr)
				`WDT_CTRL_ADDR:
					s_axi_rdata <= {24'h000000, activation_bit, count};
				`WDT_STATUS_ADDR:
					s_axi_rdata <= {27'h0000000, active, state};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `AXI_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ---- testbench/supervisor_timer_checker.sv ----
// Port checker for the supervisor timer.
// Sees only top-level ports; bound below.
`timescale 1ns/1ps
module supervisor_timer_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire timebase_irq_enable,
	input wire halt_reset_option,
	input wire halt_strobe,
	input wire reset_request,
	input wire reset_line_n,
	input wire halted
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rr_pulse;
		reset_request |=> !reset_request;
	endproperty
	a_rr_pulse: assert property (p_rr_pulse) else $error("pulse long");
	property p_line_low;
		reset_request |=> !reset_line_n [*8];
	endproperty
	a_line_low: assert property (p_line_low) else $error("line short");
	property p_line_cause;
		$fell(reset_line_n) |-> $past(reset_request);
	endproperty
	a_line_cause: assert property (p_line_cause) else $error("no cause");
	property p_halt_rst;
		halt_strobe && !timebase_irq_enable && halt_reset_option
			|-> ##[1:2] reset_request;
	endproperty
	a_halt_rst: assert property (p_halt_rst) else $error("no reset");
	property p_act_halt;
		halt_strobe && timebase_irq_enable |-> ##[1:2] halted;
	endproperty
	a_act_halt: assert property (p_act_halt) else $error("no halt");
	// Own disable: the reset edge itself is the cause here
	property p_rst_idle;
		disable iff (1'b0) !aresetn |=> reset_line_n && !halted;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("reset state");
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("no read answer");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
endmodule
bind supervisor_timer supervisor_timer_checker chk_i (.aclk(aclk),
	.aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .timebase_irq_enable(timebase_irq_enable),
	.halt_reset_option(halt_reset_option), .halt_strobe(halt_strobe),
	.reset_request(reset_request), .reset_line_n(reset_line_n),
	.halted(halted));

// ---- testbench/supervisor_timer_tb.sv ----
// Self-checking bench for the supervisor timer.
// Assumes osc_clock at full rate and timebase 0.
`timescale 1ns/1ps
`include "supervisor_timer_defines.vh"
module supervisor_timer_tb;
	reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	reg arvalid = 0, rready = 0, irq_en = 0, opt = 0, hw = 0;
	reg halt_strobe = 0, ext_wake = 0;
	reg [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
	reg [31:0] wdata = 0;
	wire awready, wready, bvalid, arready, rvalid, rr, line_n, halted;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer num_errors = 0, num_checks = 0, n, k;
	always #2.5 aclk = ~aclk;
	supervisor_timer dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .osc_clock(1'b1), .timebase_select(2'b00),
		.timebase_irq_enable(irq_en), .halt_reset_option(opt),
		.hw_watchdog_option(hw), .long_wake_delay(1'b0),
		.halt_strobe(halt_strobe), .ext_wake(ext_wake), .osc_wake(1'b0),
		.cold_from_halt(1'b0), .reset_request(rr), .reset_line_n(line_n),
		.halted(halted));
	task chk(input [31:0] exp, input [31:0] got, input [8*8:1] what);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("Error %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d, input [1:0] er);
		begin
			awaddr <= a;
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
				k = k + 1;
			end while (!bvalid && k < 50);
			bready <= 1'b0;
			chk(1, bvalid, "bvalid");
			chk(er, bresp, "bresp");
		end
	endtask
	task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				if (arready) arvalid <= 1'b0;
				k = k + 1;
			end while (!rvalid && k < 50);
			rready <= 1'b0;
			chk(1, rvalid, "rvalid");
			chk(er, rresp, "rresp");
			chk(ed, rdata, "rdata");
		end
	endtask
	task wait_rr(input integer lim);
		begin
			n = 0;
			while (rr !== 1'b1 && n < lim) begin
				@(posedge aclk);
				n = n + 1;
			end
		end
	endtask
	// Lets the reset line pulse finish before resetting again
	task do_reset;
		begin
			repeat (110) @(posedge aclk);
			aresetn <= 1'b0;
			repeat (5) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
		end
	endtask
	task pulse_halt;
		begin
			halt_strobe <= 1'b1;
			@(posedge aclk);
			halt_strobe <= 1'b0;
		end
	endtask
	// All within the first prescaler period, so no tick interferes
	task t_regs;
		begin
			rd(4'h0, 32'h7f, `AXI_OKAY);
			wr(4'h0, 8'h45, `AXI_OKAY);
			rd(4'h0, 32'h45, `AXI_OKAY);
			wr(4'h0, 8'h00, `AXI_OKAY);
			wait_rr(200);
			chk(200, n, "inactive");
			rd(4'h8, 32'h0, `AXI_SLVERR);
			wr(4'h4, 8'h00, `AXI_SLVERR);
			rd(4'h0, 32'h00, `AXI_OKAY);
			wr(4'h0, 8'hc5, `AXI_OKAY);
			wr(4'h0, 8'h45, `AXI_OKAY);
			rd(4'h0, 32'hc5, `AXI_OKAY);
			do_reset;
		end
	endtask
	task t_timeout;
		begin
			wr(4'h0, 8'hc0, `AXI_OKAY);
			wait_rr(17000);
			// Lower bound is (59 + 128) * 64 for timebase 0
			chk(1, n >= 11968 && n <= 16384, "timeout");
			do_reset;
		end
	endtask
	task t_soft;
		begin
			wr(4'h0, 8'h80, `AXI_OKAY);
			wait_rr(8);
			chk(1, n < 8, "soft");
			do_reset;
			hw <= 1'b1;
			wr(4'h0, 8'h00, `AXI_OKAY);
			wait_rr(8);
			chk(1, n < 8, "hwopt");
			hw <= 1'b0;
			do_reset;
		end
	endtask
	task t_halts;
		begin
			opt <= 1'b1;
			pulse_halt;
			wait_rr(8);
			chk(1, n < 8, "haltrst");
			opt <= 1'b0;
			do_reset;
			wr(4'h0, 8'h7f, `AXI_OKAY);
			irq_en <= 1'b1;
			pulse_halt;
			wait_rr(3);
			chk(3, n, "norst");
			chk(1, halted, "halted");
			rd(4'h4, 32'h04, `AXI_OKAY);
			ext_wake <= 1'b1;
			@(posedge aclk);
			ext_wake <= 1'b0;
			repeat (3) @(posedge aclk);
			chk(0, halted, "woken");
			irq_en <= 1'b0;
			do_reset;
			pulse_halt;
			rd(4'h4, 32'h02, `AXI_OKAY);
			chk(1, halted, "plainhlt");
			do_reset;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", num_checks, num_errors);
			if (num_errors == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		do_reset;
		t_regs;
		t_timeout;
		t_soft;
		t_halts;
		print_verdict;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule
